// ===== rps_top.sv
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module rps_top #(
  parameter int MS_CYCLES = rps_pkg::MS_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic current_over,
  input wire logic over_temp,
  input wire logic mains_reconnect,
  input wire logic cycle_start,
  input wire logic ls_request,
  input wire logic hs_request,
  input wire logic [9:0] capacitor_swing,
  input wire logic measure_valid,
  input wire logic [11:0] burst_select_resistor,
  input wire logic [11:0] general_select_resistor,
  input wire logic [11:0] transition_select_resistor,
  output logic low_side_gate,
  output logic high_side_gate,
  output logic switching_enable,
  output logic boost_pull_low,
  output logic supply_hold,
  output logic power_good_warn,
  output logic [9:0] swing_clamped,
  output logic [1:0] burst_freq_sel,
  output logic [7:0] lp_level,
  output logic [7:0] burst_level,
  output logic irq,
  input wire logic [7:0] axi_awaddr,
  input wire logic axi_awvalid,
  output logic axi_awready,
  input wire logic [31:0] axi_wdata,
  input wire logic [3:0] axi_wstrb,
  input wire logic axi_wvalid,
  output logic axi_wready,
  output logic [1:0] axi_bresp,
  output logic axi_bvalid,
  input wire logic axi_bready,
  input wire logic [7:0] axi_araddr,
  input wire logic axi_arvalid,
  output logic axi_arready,
  output logic [31:0] axi_rdata,
  output logic [1:0] axi_rresp,
  output logic axi_rvalid,
  input wire logic axi_rready
);
  import rps_pkg::*;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  rps_state_type state;
  rps_state_type next_state;
  logic [1:0] oc_sync;
  logic [1:0] ot_sync;
  logic [1:0] mr_sync;
  logic oc_cut;
  logic cycle_oc;
  logic [2:0] oc_count;
  logic [15:0] ms_div;
  logic ms_tick;
  logic [10:0] opp_ms;
  logic [10:0] restart_ms;
  logic run_enable;
  logic [4:0] irq_status;
  logic [4:0] irq_mask;
  logic [3:0] gen_code;
  logic [2:0] trn_code;
  logic gen_short;
  logic ocp_latched;
  logic otp_latched;
  logic opp_latched;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Synchronisers for pin-side levels
  always_ff @(posedge clock) begin
    oc_sync <= {oc_sync[0], current_over};
    ot_sync <= {ot_sync[0], over_temp};
    mr_sync <= {mr_sync[0], mains_reconnect};
  end
  wire oc_now = oc_sync[1];
  wire ot_now = ot_sync[1];
  wire mains_back = mr_sync[1];

  // Nearest-code classification of the measured resistors
  wire [1:0] next_burst = (burst_select_resistor >= BURST_T0) ? 2'h0 :
                          (burst_select_resistor >= BURST_T1) ? 2'h1 :
                          (burst_select_resistor >= BURST_T2) ? 2'h2 : 2'h3;
  wire [3:0] next_gen = (general_select_resistor < GEN_T0) ? 4'h0 :
                        (general_select_resistor < GEN_T1) ? 4'h1 :
                        (general_select_resistor < GEN_T2) ? 4'h2 :
                        (general_select_resistor < GEN_T3) ? 4'h3 :
                        (general_select_resistor < GEN_T4) ? 4'h4 :
                        (general_select_resistor < GEN_T5) ? 4'h5 :
                        (general_select_resistor < GEN_T6) ? 4'h6 :
                        (general_select_resistor < GEN_T7) ? 4'h7 : 4'h8;
  wire [2:0] next_trn = (transition_select_resistor < TRN_T0) ? 3'h0 :
                        (transition_select_resistor < TRN_T1) ? 3'h1 :
                        (transition_select_resistor < TRN_T2) ? 3'h2 :
                        (transition_select_resistor < TRN_T3) ? 3'h3 :
                        (transition_select_resistor < TRN_T4) ? 3'h4 :
                        (transition_select_resistor < TRN_T5) ? 3'h5 :
                        (transition_select_resistor < TRN_T6) ? 3'h6 : 3'h7;
  wire settings_take = (state == ST_MEASURE) && measure_valid;

  // Setting latch, taken once before switching
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      burst_freq_sel <= 2'h0;
      gen_code <= 4'h0;
      trn_code <= 3'h0;
      gen_short <= 1'b1;
    end else if (settings_take) begin
      burst_freq_sel <= next_burst;
      gen_code <= next_gen;
      trn_code <= next_trn;
      gen_short <= (general_select_resistor < GEN_SHORT);
    end
  end

  // Decoded general settings
  wire timer_off = (gen_code == 4'h0);
  wire cap_200 = (gen_code == 4'h0) || (gen_code == 4'h1) || (gen_code == 4'h2) ||
                 (gen_code == 4'h5) || (gen_code == 4'h6);
  wire timer_long = gen_code[0];
  wire opp_latch_mode = (gen_code >= 4'h5);
  wire [10:0] opp_limit = timer_long ? OPP_LONG_MS : OPP_SHORT_MS;
  wire [10:0] pg_limit = timer_long ? PG_LONG_MS : PG_SHORT_MS;

  // Transition and burst entry levels
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lp_level <= 8'h00;
      burst_level <= 8'h00;
    end else begin
      lp_level <= LP_LEVEL[trn_code[2:1]];
      burst_level <= BURST_LEVEL[{trn_code, burst_freq_sel}];
    end
  end

  // Swing clamp at the capability maximum
  wire [9:0] swing_max = cap_200 ? SWING_MAX_200 : SWING_MAX_150;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      swing_clamped <= 10'h000;
    end else begin
      swing_clamped <= (capacitor_swing > swing_max) ? swing_max : capacitor_swing;
    end
  end

  // Millisecond enable divider
  always_ff @(posedge clock) begin
    if (sys_rst || ms_tick) begin
      ms_div <= 16'h0000;
    end else begin
      ms_div <= ms_div + 16'h0001;
    end
  end
  assign ms_tick = (ms_div == 16'(MS_CYCLES - 1));

  // Overpower counter
  wire running = (state == ST_RUN);
  wire opp_active = running && !timer_off && (capacitor_swing > OPP_SWING_THRESHOLD);
  wire opp_trip = opp_active && (opp_ms > opp_limit);
  always_ff @(posedge clock) begin
    if (sys_rst || !opp_active) begin
      opp_ms <= 11'h000;
    end else if (ms_tick && !opp_trip) begin
      opp_ms <= opp_ms + 11'h001;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      power_good_warn <= 1'b0;
    end else begin
      power_good_warn <= opp_active && (opp_ms >= pg_limit);
    end
  end

  // Cycle-by-cycle overcurrent cut and consecutive count
  wire oc_cycle_end = cycle_start && cycle_oc;
  wire ocp_trip = running && oc_cycle_end && (oc_count == OCP_CYCLE_LIMIT - 3'h1);
  always_ff @(posedge clock) begin
    if (sys_rst || !running) begin
      oc_cut <= 1'b0;
      cycle_oc <= 1'b0;
      oc_count <= 3'h0;
    end else if (cycle_start) begin
      oc_cut <= 1'b0;
      cycle_oc <= 1'b0;
      oc_count <= cycle_oc ? oc_count + 3'h1 : 3'h0;
    end else if (oc_now && (ls_request || hs_request)) begin
      oc_cut <= 1'b1;
      cycle_oc <= 1'b1;
    end
  end
  assign low_side_gate = running && ls_request && !oc_cut && !oc_now;
  assign high_side_gate = running && hs_request && !oc_cut && !oc_now;

  // Restart timer for timed overpower recovery
  always_ff @(posedge clock) begin
    if (sys_rst || state != ST_RESTART) begin
      restart_ms <= 11'h000;
    end else if (ms_tick) begin
      restart_ms <= restart_ms + 11'h001;
    end
  end

  // Protection state machine
  always_comb begin
    next_state = state;
    unique case (state)
      ST_MEASURE: begin
        if (settings_take) begin
          next_state = (general_select_resistor < GEN_SHORT) ? ST_INHIBIT : ST_RUN;
        end
      end
      ST_RUN: begin
        if (ot_now || ocp_trip) begin
          next_state = ST_LATCHED;
        end else if (opp_trip) begin
          next_state = opp_latch_mode ? ST_LATCHED : ST_RESTART;
        end
      end
      ST_INHIBIT: begin
        if (mains_back) begin
          next_state = ST_MEASURE;
        end
      end
      ST_LATCHED: begin
        if (mains_back) begin
          next_state = ST_MEASURE;
        end
      end
      ST_RESTART: begin
        if (mains_back) begin
          next_state = ST_MEASURE;
        end else if (restart_ms == RESTART_MS) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_MEASURE;
    endcase
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= ST_MEASURE;
    end else begin
      state <= next_state;
    end
  end

  // Latch cause flags, cleared only by mains return
  always_ff @(posedge clock) begin
    if (sys_rst || mains_back) begin
      ocp_latched <= 1'b0;
      otp_latched <= 1'b0;
      opp_latched <= 1'b0;
    end else if (running) begin
      ocp_latched <= ocp_latched | (ocp_trip && !ot_now);
      otp_latched <= otp_latched | ot_now;
      opp_latched <= opp_latched | (opp_trip && opp_latch_mode && !ot_now && !ocp_trip);
    end
  end

  // Pin-side outputs
  assign switching_enable = running && run_enable;
  assign boost_pull_low = !running;
  assign supply_hold = (state == ST_LATCHED) || (state == ST_RESTART);

  // Register write channel
  wire aw_take = axi_awvalid && axi_awready;
  wire w_take = axi_wvalid && axi_wready;
  wire wr_go = aw_held && w_held && !axi_bvalid;
  wire wr_ctrl = wr_go && (aw_addr == REG_CONTROL);
  wire wr_mask = wr_go && (aw_addr == REG_IRQ_MASK);
  wire wr_ok = wr_ctrl || wr_mask || (aw_addr == REG_STATUS) || (aw_addr == REG_SETTINGS) ||
               (aw_addr == REG_IRQ_STATUS) || (aw_addr == REG_OPP_COUNT);
  assign axi_awready = !aw_held;
  assign axi_wready = !w_held;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      axi_bvalid <= 1'b0;
      axi_bresp <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= {axi_awaddr[7:2], 2'h0};
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= axi_wdata;
        w_strb <= axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        axi_bvalid <= 1'b1;
        axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (axi_bready) begin
        axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable control and mask
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      run_enable <= 1'b0;
      irq_mask <= IRQ_MASK_RESET;
    end else begin
      if (wr_ctrl && w_strb[0]) begin
        run_enable <= w_data[0];
      end
      if (wr_mask && w_strb[0]) begin
        irq_mask <= w_data[4:0];
      end
    end
  end

  // Register read channel
  wire ar_take = axi_arvalid && axi_arready;
  wire [7:0] ar_addr = {axi_araddr[7:2], 2'h0};
  wire rd_irq = ar_take && (ar_addr == REG_IRQ_STATUS);
  wire [31:0] rd_word =
    (ar_addr == REG_CONTROL) ? {31'h0, run_enable} :
    (ar_addr == REG_STATUS) ? {24'h0, opp_latched, otp_latched, ocp_latched, state} :
    (ar_addr == REG_SETTINGS) ? {20'h0, gen_short, trn_code, gen_code, burst_freq_sel, 2'h0} :
    (ar_addr == REG_IRQ_STATUS) ? {27'h0, irq_status} :
    (ar_addr == REG_IRQ_MASK) ? {27'h0, irq_mask} :
    (ar_addr == REG_OPP_COUNT) ? {21'h0, opp_ms} : 32'h0000_0000;
  wire rd_ok = (ar_addr <= REG_OPP_COUNT);
  assign axi_arready = !axi_rvalid;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      axi_rvalid <= 1'b0;
      axi_rdata <= 32'h0000_0000;
      axi_rresp <= RESP_OKAY;
    end else if (ar_take) begin
      axi_rvalid <= 1'b1;
      axi_rdata <= rd_word;
      axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (axi_rready) begin
      axi_rvalid <= 1'b0;
    end
  end

  // Sticky interrupt status, set wins over read clear
  wire [4:0] irq_event;
  assign irq_event[IRQ_OCP_CYCLE] = running && oc_now && !oc_cut && (ls_request || hs_request);
  assign irq_event[IRQ_OCP_LATCH] = ocp_trip;
  assign irq_event[IRQ_OTP_LATCH] = running && ot_now;
  assign irq_event[IRQ_OPP_TRIP] = opp_trip;
  assign irq_event[IRQ_SETTINGS] = settings_take;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_status <= 5'h00;
    end else begin
      irq_status <= (irq_status & {5{!rd_irq}}) | irq_event;
    end
  end
  assign irq = |(irq_status & irq_mask);

  // Checks
  AST_OC_CUT: assert property (running && oc_now && ls_request |-> !low_side_gate)
    else $error("low gate on during overcurrent");
  AST_OC_FIVE: assert property (running && !ot_now && !opp_trip && ocp_trip |=> state == ST_LATCHED)
    else $error("fifth overcurrent cycle did not latch");
  AST_OC_BOOST: assert property (ocp_trip |=> boost_pull_low && ocp_latched)
    else $error("boost not pulled low after overcurrent latch");
  AST_OTP: assert property (running && ot_now |=> state == ST_LATCHED ##0 boost_pull_low)
    else $error("overtemperature did not latch");
  AST_OPP_COUNT: assert property (opp_active && ms_tick && !opp_trip |=> opp_ms == $past(opp_ms) + 11'h001)
    else $error("overpower counter did not advance");
  AST_OPP_TRIP: assert property (running && opp_trip && !ot_now && !ocp_trip && !opp_latch_mode
    |=> state == ST_RESTART)
    else $error("timed restart not entered");
  AST_CLAMP: assert property (##1 swing_clamped <= $past(swing_max))
    else $error("swing above capability limit");
  AST_TIMER_OFF: assert property (timer_off |-> opp_ms == 11'h000 && !opp_trip)
    else $error("disabled overpower counter ran");
  AST_MEASURE_FIRST: assert property (state == ST_MEASURE |-> !low_side_gate && !high_side_gate)
    else $error("switching before settings");
  AST_SUPPLY: assert property (state == ST_LATCHED |-> supply_hold)
    else $error("supply not held in protection");
  AST_LATCH_HOLD: assert property (state == ST_LATCHED && !mains_back |=> state == ST_LATCHED)
    else $error("latch released without mains return");
  AST_SHORT: assert property (settings_take && general_select_resistor < GEN_SHORT |=> state == ST_INHIBIT)
    else $error("short pin did not inhibit");
endmodule // rps_top

// ===== rps_pkg.sv
package rps_pkg;
  // Clock and time base
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DEF = (MS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  // Protection figures
  localparam logic [2:0] OCP_CYCLE_LIMIT = 3'h5;
  localparam logic [10:0] OPP_LONG_MS = 11'h0c8;
  localparam logic [10:0] OPP_SHORT_MS = 11'h032;
  localparam logic [10:0] PG_LONG_MS = 11'h0be;
  localparam logic [10:0] PG_SHORT_MS = 11'h02d;
  localparam logic [10:0] RESTART_MS = 11'h3e8;
  // Capacitor swing codes
  localparam logic [9:0] OPP_SWING_THRESHOLD = 10'h200;
  localparam logic [9:0] SWING_MAX_150 = 10'h266;
  localparam logic [9:0] SWING_MAX_200 = 10'h333;
  // Resistor classification thresholds, units of 100 ohm
  localparam logic [11:0] BURST_T0 = 12'h0b9;
  localparam logic [11:0] BURST_T1 = 12'h07d;
  localparam logic [11:0] BURST_T2 = 12'h054;
  localparam logic [11:0] GEN_SHORT = 12'h064;
  localparam logic [11:0] GEN_T0 = 12'h1f4;
  localparam logic [11:0] GEN_T1 = 12'h242;
  localparam logic [11:0] GEN_T2 = 12'h29b;
  localparam logic [11:0] GEN_T3 = 12'h302;
  localparam logic [11:0] GEN_T4 = 12'h379;
  localparam logic [11:0] GEN_T5 = 12'h403;
  localparam logic [11:0] GEN_T6 = 12'h4a1;
  localparam logic [11:0] GEN_T7 = 12'h569;
  localparam logic [11:0] TRN_T0 = 12'h027;
  localparam logic [11:0] TRN_T1 = 12'h06d;
  localparam logic [11:0] TRN_T2 = 12'h0d2;
  localparam logic [11:0] TRN_T3 = 12'h172;
  localparam logic [11:0] TRN_T4 = 12'h285;
  localparam logic [11:0] TRN_T5 = 12'h51e;
  localparam logic [11:0] TRN_T6 = 12'hbb8;
  // Transition levels in half percent, indexed by level code
  localparam logic [7:0] LP_LEVEL [0:3] = '{8'h32, 8'h4b, 8'h64, 8'h7d};
  // Burst entry levels in half percent, index = transition code * 4 + burst code
  localparam logic [7:0] BURST_LEVEL [0:31] = '{
    8'h12, 8'h12, 8'h12, 8'h12, 8'h18, 8'h18, 8'h18, 8'h18,
    8'h12, 8'h12, 8'h12, 8'h14, 8'h18, 8'h18, 8'h18, 8'h1a,
    8'h12, 8'h14, 8'h16, 8'h18, 8'h18, 8'h1a, 8'h1e, 8'h22,
    8'h12, 8'h14, 8'h18, 8'h1c, 8'h18, 8'h1e, 8'h23, 8'h28};
  // Register map, byte addresses
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SETTINGS = 8'h08;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_OPP_COUNT = 8'h14;
  localparam logic [4:0] IRQ_MASK_RESET = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Interrupt bit positions
  localparam int IRQ_OCP_CYCLE = 0;
  localparam int IRQ_OCP_LATCH = 1;
  localparam int IRQ_OTP_LATCH = 2;
  localparam int IRQ_OPP_TRIP = 3;
  localparam int IRQ_SETTINGS = 4;
  // Controller states
  typedef enum logic [4:0] {
    ST_MEASURE = 5'h01,
    ST_RUN = 5'h02,
    ST_INHIBIT = 5'h04,
    ST_LATCHED = 5'h08,
    ST_RESTART = 5'h10
  } rps_state_type;
endpackage

// ===== rps_stage_model.sv
`timescale 1ns/10ps
// Half-bridge stage, modulator and boost divider as seen from the controller pins
module rps_stage_model (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic low_side_gate,
  input wire logic high_side_gate,
  input wire logic boost_pull_low,
  input wire logic over_en,
  output logic cycle_start,
  output logic ls_request,
  output logic hs_request,
  output logic current_over,
  output logic boost_level
);
  logic [3:0] phase;

  // Sixteen clock switching cycle, low side first, dead time between halves
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      phase <= 4'h0;
      cycle_start <= 1'b0;
      ls_request <= 1'b0;
      hs_request <= 1'b0;
      current_over <= 1'b0;
    end else begin
      phase <= phase + 4'h1;
      cycle_start <= (phase == 4'hf);
      ls_request <= (phase < 4'h7);
      hs_request <= (phase >= 4'h8) && (phase != 4'hf);
      current_over <= over_en && (low_side_gate || high_side_gate); // Only a conducting switch carries current
    end
  end

  // Divider pulls the boost line up unless the controller sinks it
  assign boost_level = !boost_pull_low;
endmodule // rps_stage_model

// ===== tb.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module tb;
  import rps_pkg::*;
  logic clock, sys_rst, over_en, over_temp, mains_reconnect, measure_valid, cyc_start, ls_req, hs_req, cur_over;
  logic boost_level, ls_gate, hs_gate, sw_en, boost_low, sup_hold, pg_warn, irq;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [9:0] swing, swing_clamped;
  logic [11:0] burst_res, gen_res, trn_res;
  logic [1:0] freq_sel, bresp, rresp, resp;
  logic [7:0] lp_level, burst_level, awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  int n_mismatch, tests_run, cyc;

  // Partner stage and design, timer shortened to ten clocks a millisecond
  rps_stage_model u_stage (.clock(clock), .sys_rst(sys_rst), .low_side_gate(ls_gate), .high_side_gate(hs_gate),
    .boost_pull_low(boost_low), .over_en(over_en), .cycle_start(cyc_start), .ls_request(ls_req),
    .hs_request(hs_req), .current_over(cur_over), .boost_level(boost_level));
  rps_top #(.MS_CYCLES(10)) u_dut (.clock(clock), .sys_rst(sys_rst), .current_over(cur_over),
    .over_temp(over_temp), .mains_reconnect(mains_reconnect), .cycle_start(cyc_start), .ls_request(ls_req),
    .hs_request(hs_req), .capacitor_swing(swing), .measure_valid(measure_valid),
    .burst_select_resistor(burst_res), .general_select_resistor(gen_res), .transition_select_resistor(trn_res),
    .low_side_gate(ls_gate), .high_side_gate(hs_gate), .switching_enable(sw_en), .boost_pull_low(boost_low),
    .supply_hold(sup_hold), .power_good_warn(pg_warn), .swing_clamped(swing_clamped),
    .burst_freq_sel(freq_sel), .lp_level(lp_level), .burst_level(burst_level), .irq(irq),
    .axi_awaddr(awaddr), .axi_awvalid(awvalid), .axi_awready(awready), .axi_wdata(wdata), .axi_wstrb(4'hf),
    .axi_wvalid(wvalid), .axi_wready(wready), .axi_bresp(bresp), .axi_bvalid(bvalid), .axi_bready(bready),
    .axi_araddr(araddr), .axi_arvalid(arvalid), .axi_arready(arready), .axi_rdata(rdata), .axi_rresp(rresp),
    .axi_rvalid(rvalid), .axi_rready(rready));

  // Free running clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up;
    end
  end

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Write cycle, address and data offered together, each released when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_hs, w_hs, b_hs;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs) begin
      @(negedge clock);
      aw_hs = (awvalid && awready) === 1'b1;
      w_hs = (wvalid && wready) === 1'b1;
      b_hs = bvalid === 1'b1;
      resp = bresp;
      @(posedge clock);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge clock);
  endtask

  // Read cycle, data and response left in rd and resp
  task automatic axi_read(input logic [7:0] a);
    logic ar_hs, r_hs;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs) begin
      @(negedge clock);
      ar_hs = (arvalid && arready) === 1'b1;
      r_hs = rvalid === 1'b1;
      rd = rdata;
      resp = rresp;
      @(posedge clock);
      if (ar_hs) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge clock);
  endtask

  task automatic chk_state(input logic [4:0] e);
    axi_read(REG_STATUS);
    `CHK("state", e, rd[4:0])
  endtask

  // Counts conducting clocks and clocks where a requested gate is held off
  task automatic watch(input int n, output int on_n, output int cut_n);
    on_n = 0;
    cut_n = 0;
    repeat (n) begin
      @(negedge clock);
      on_n += int'(ls_gate === 1'b1 || hs_gate === 1'b1);
      cut_n += int'((ls_req && !ls_gate) === 1'b1 || (hs_req && !hs_gate) === 1'b1);
    end
    @(posedge clock);
  endtask

  // Leave protection through a mains return and take a fresh set of readings
  task automatic remeasure(input logic [11:0] b, input logic [11:0] g, input logic [11:0] t);
    swing <= 10'h000;
    mains_reconnect <= 1'b1;
    repeat (4) @(posedge clock);
    mains_reconnect <= 1'b0;
    burst_res <= b;
    gen_res <= g;
    trn_res <= t;
    repeat (4) @(posedge clock);
    measure_valid <= 1'b1;
    @(posedge clock);
    measure_valid <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  task automatic t_reset;
    int on_n, cut_n;
    watch(40, on_n, cut_n);
    `CHK("gates before settings", 0, on_n)
    `CHK("boost line", 1'b0, boost_level)
    chk_state(5'h01);
    axi_read(8'h18);
    `CHK("unmapped read", RESP_SLVERR, resp)
    axi_write(8'h18, 32'h1);
    `CHK("unmapped write", RESP_SLVERR, resp)
    $display("t_reset done");
  endtask

  task automatic t_decode;
    logic [11:0] bres [0:3];
    logic [11:0] tres [0:7];
    logic [7:0] lp [0:7];
    logic [7:0] bl [0:7];
    bres = '{12'h0dc, 12'h096, 12'h064, 12'h044};
    tres = '{12'h00a, 12'h044, 12'h096, 12'h10e, 12'h1d6, 12'h334, 12'h708, 12'hfff};
    lp = '{8'h32, 8'h32, 8'h4b, 8'h4b, 8'h64, 8'h64, 8'h7d, 8'h7d};
    bl = '{8'h12, 8'h18, 8'h12, 8'h1a, 8'h12, 8'h1a, 8'h18, 8'h28};
    for (int i = 0; i < 8; i++) begin
      remeasure(bres[i % 4], 12'h032, tres[i]);
      `CHK("burst freq", 2'(i % 4), freq_sel)
      `CHK("low power level", lp[i], lp_level)
      `CHK("burst level", bl[i], burst_level)
      chk_state(5'h04);
      axi_read(REG_SETTINGS);
      `CHK("settings short and level", {1'b1, 3'(i)}, rd[11:8])
    end
    $display("t_decode done");
  endtask

  task automatic t_ocp;
    int on_n, cut_n;
    remeasure(12'h0dc, 12'h3b9, 12'hfff);
    axi_read(REG_IRQ_STATUS);
    axi_write(REG_IRQ_MASK, 32'h2);
    axi_write(REG_CONTROL, 32'h1);
    over_en <= 1'b1;
    watch(40, on_n, cut_n);
    `CHK("keeps switching", 1'b1, on_n > 0)
    `CHK("gate cut", 1'b1, cut_n > 0)
    `CHK("cut masked", 1'b0, irq)
    for (int i = 0; i < 120 && irq !== 1'b1; i++) @(negedge clock);
    `CHK("latch irq", 1'b1, irq)
    `CHK("latched gates", 2'b00, {ls_gate, hs_gate})
    `CHK("run flag", 1'b0, sw_en)
    `CHK("boost pulled", 1'b0, boost_level)
    `CHK("supply hold", 1'b1, sup_hold)
    @(posedge clock);
    over_en <= 1'b0;
    axi_read(REG_IRQ_STATUS);
    `CHK("irq events", 2'b11, rd[1:0])
    watch(100, on_n, cut_n);
    `CHK("no timer release", 0, on_n)
    `CHK("irq cleared", 1'b0, irq)
    chk_state(5'h08);
    `CHK("ocp flag", 1'b1, rd[5])
    $display("t_ocp done");
  endtask

  task automatic t_otp;
    remeasure(12'h0dc, 12'h3b9, 12'hfff);
    axi_write(REG_IRQ_MASK, 32'h4);
    over_temp <= 1'b1;
    for (int i = 0; i < 10 && irq !== 1'b1; i++) @(negedge clock);
    `CHK("otp irq", 1'b1, irq)
    `CHK("otp boost", 1'b0, boost_level)
    @(posedge clock);
    over_temp <= 1'b0;
    chk_state(5'h08);
    `CHK("otp flag", 1'b1, rd[6])
    axi_read(REG_IRQ_STATUS);
    `CHK("otp irq bit", 1'b1, rd[IRQ_OTP_LATCH])
    $display("t_otp done");
  endtask

  // Sustained overpower for one general setting code
  task automatic t_opp(input logic [11:0] g, input int mid, input logic [9:0] clamp, input logic [4:0] e);
    remeasure(12'h0dc, g, 12'hfff);
    swing <= 10'h3ff;
    repeat (mid) @(negedge clock);
    `CHK("swing clamp", clamp, swing_clamped)
    if (e != 5'h02) `CHK("power good end", 1'b1, pg_warn)
    @(posedge clock);
    chk_state(5'h02);
    repeat (200) @(posedge clock);
    chk_state(e);
    @(negedge clock);
    `CHK("supply hold", e != 5'h02, sup_hold)
    @(posedge clock);
    $display("t_opp done");
  endtask

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    {over_en, over_temp, mains_reconnect, measure_valid, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, swing} = '0;
    {burst_res, gen_res, trn_res} = {12'h0dc, 12'h3b9, 12'hfff};
    {n_mismatch, tests_run, cyc} = '0;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_reset;
    t_decode;
    t_ocp;
    t_otp;
    t_opp(12'h3b9, 1950, 10'h333, 5'h08);
    t_opp(12'h339, 470, 10'h266, 5'h10);
    t_opp(12'h1d0, 2300, 10'h333, 5'h02);
    wrap_up;
  end
endmodule // tb
